// ### hdl/lcdx_pkg.sv
// shared constants and types for the lcd power-mode and segment-expansion block
package lcdx_pkg;
  // device power state as the power manager reports it
  typedef enum logic [2:0] {
    PM_RESET  = 3'h0,
    PM_ACTIVE = 3'h1,
    PM_SLEEP  = 3'h2,
    PM_WATCH  = 3'h3,
    PM_SUBACT = 3'h4,
    PM_SUBSLP = 3'h5,
    PM_STANDBY= 3'h6
  } lcdx_pmode_e;

  // expansion engine states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_SHIFT = 3'h2,
    ST_LATCH = 3'h4
  } lcdx_state_e;

  // one bundle per expansion pin group: values or enables
  typedef struct packed {
    logic latch_clk;
    logic shift_clk;
    logic ac_phase;
    logic ser_data;
  } lcdx_exp_s;

  // frame clock select layout: bit 3 picks the subclock
  localparam int unsigned FCS_SUB_BIT  = 3;
  localparam int unsigned FCS_DIV_LSB  = 0;
  localparam logic [1:0]  SUB_DIV_1    = 2'h0;
  localparam logic [1:0]  SUB_DIV_2    = 2'h1;
  localparam logic [1:0]  SUB_DIV_4    = 2'h2;
  // segment select codes that allow expansion
  localparam logic [3:0]  SGS_EXP_A    = 4'h0;
  localparam logic [3:0]  SGS_EXP_B    = 4'h1;
  // reset values and system divider width
  localparam logic [2:0]  SUB_SYNC_RST = 3'h0;
  localparam logic [7:0]  DIV_CNT_RST  = 8'h00;
  localparam int unsigned SYS_DIV_W    = 8;
endpackage

// ### hdl/lcdx_ctrl.sv
// lcd controller power-mode gating and serial segment-expansion driver
`timescale 1ns/100ps
`default_nettype none
// Contract
// - sub-clock modes run display only on subclock source
// - run bit clear keeps display stopped always
// - run bit set: display runs in active/sleep, and in sub modes on subclock source
// - standby blocks subclock delivery to display
// - standby forces lcd drive supply off
// - module standby stops controller clock, halts display
// - serial data from segment one; low pins ports
// - run clear freezes clocks, phase low, data held
// - standby floats all expansion pins
// - drive level from data and phase together
module lcdx_ctrl #(
  parameter int unsigned SER_BITS = 80,  // bits per expansion frame
  parameter int unsigned ADDR_W   = 7    // display ram bit address width
) (
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  input  wire lcdx_pkg::lcdx_pmode_e    power_mode,
  input  wire logic                     module_standby,
  input  wire logic                     display_run_bit,
  input  wire logic [3:0]               frame_clock_select,
  input  wire logic                     drive_supply_switch_bit,
  input  wire logic                     expansion_select_bit,
  input  wire logic [3:0]               segment_pin_select_field,
  input  wire logic                     sub_clk_pin,
  input  wire logic                     ram_bit,
  output logic [ADDR_W-1:0]             ram_addr,
  output lcdx_pkg::lcdx_exp_s           exp_out,
  output lcdx_pkg::lcdx_exp_s           exp_oe,
  output logic [1:0]                    seg_level_code,
  output logic                          drive_supply_on,
  output logic                          lower_seg_port_mode,
  output logic                          display_running
);

  // sys divider limit for frame_clock_select[2:0]
  function automatic logic [7:0] sys_limit(input logic [2:0] sel);
    sys_limit = 8'((9'h001 << sel) - 9'h001);
  endfunction

  // subclock synchroniser: three stages, filtered level
  logic [2:0] sub_sync_r;      // s0 feeds s1 only
  logic       sub_lvl_r;       // agreed subclock level
  logic [7:0] sys_cnt_r;       // system clock prescaler
  logic [1:0] sub_cnt_r;       // subclock divider
  lcdx_pkg::lcdx_state_e state_r;
  lcdx_pkg::lcdx_state_e state_nxt;
  logic [ADDR_W-1:0] bit_cnt_r;  // next bit to send
  logic       shift_r;
  logic       latch_r;
  logic       phase_r;
  logic       data_r;
  logic       running_r;
  logic       oe_r;
  logic       supply_r;
  logic       port_r;
  logic [1:0] level_r;

  // decode of source, mode and availability
  wire use_sub   = frame_clock_select[lcdx_pkg::FCS_SUB_BIT];
  wire [1:0] sub_div = frame_clock_select[lcdx_pkg::FCS_DIV_LSB +: 2];
  wire is_standby = (power_mode == lcdx_pkg::PM_STANDBY);
  wire sys_runs  = (power_mode == lcdx_pkg::PM_ACTIVE) ||
                   (power_mode == lcdx_pkg::PM_SLEEP);
  wire sub_mode  = (power_mode == lcdx_pkg::PM_WATCH) ||
                   (power_mode == lcdx_pkg::PM_SUBACT) ||
                   (power_mode == lcdx_pkg::PM_SUBSLP);
  // subclock reaches us in all but standby and reset
  wire sub_avail = sys_runs || sub_mode;
  // without system clock only the subclock source survives
  wire clk_avail = use_sub ? sub_avail : sys_runs;
  // module standby kills the controller clock outright
  wire run_ok    = display_run_bit && clk_avail && !module_standby;
  wire exp_mode  = expansion_select_bit &&
                   ((segment_pin_select_field == lcdx_pkg::SGS_EXP_A) ||
                    (segment_pin_select_field == lcdx_pkg::SGS_EXP_B));

  // subclock edge only once stages two and three agree
  wire sub_agree = (sub_sync_r[1] == sub_sync_r[2]);
  wire sub_rise  = sub_agree && sub_sync_r[2] && !sub_lvl_r;
  wire sub_last  = (sub_div == lcdx_pkg::SUB_DIV_4) ? (sub_cnt_r == 2'h3) :
                   (sub_div == lcdx_pkg::SUB_DIV_2) ? (sub_cnt_r[0]) : 1'b1;
  wire sub_tick  = sub_rise && sub_last;
  wire sys_tick  = (sys_cnt_r == sys_limit(frame_clock_select[2:0]));
  // every strobe edge lands on a tick except at a freeze, so only a freeze shortens a pulse
  wire tick      = run_ok && (use_sub ? sub_tick : sys_tick);
  wire last_bit  = (bit_cnt_r == ADDR_W'(SER_BITS - 1));

  // synchroniser and filtered level
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sub_sync_r <= lcdx_pkg::SUB_SYNC_RST;
      sub_lvl_r  <= 1'b0;
    end else begin
      sub_sync_r <= {sub_sync_r[1:0], sub_clk_pin};
      if (sub_agree)
        sub_lvl_r <= sub_sync_r[2];
    end
  end

  // dividers; held at zero while stopped so restart is clean
  always_ff @(posedge sys_clk) begin
    if (!nrst || !run_ok) begin
      sys_cnt_r <= lcdx_pkg::DIV_CNT_RST;
      sub_cnt_r <= 2'h0;
    end else begin
      sys_cnt_r <= sys_tick ? lcdx_pkg::DIV_CNT_RST : sys_cnt_r + 8'h01;
      if (sub_rise)
        sub_cnt_r <= sub_cnt_r + 2'h1;
    end
  end

  // next-state choice for the expansion engine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      lcdx_pkg::ST_IDLE: begin
        if (run_ok && exp_mode)
          state_nxt = lcdx_pkg::ST_SHIFT;
      end
      lcdx_pkg::ST_SHIFT: begin
        if (tick && shift_r && last_bit)
          state_nxt = lcdx_pkg::ST_LATCH;
      end
      lcdx_pkg::ST_LATCH: begin
        if (tick && latch_r)
          state_nxt = lcdx_pkg::ST_SHIFT;
      end
      default: state_nxt = lcdx_pkg::ST_IDLE;
    endcase
    if (!run_ok || !exp_mode)
      state_nxt = lcdx_pkg::ST_IDLE;
  end

  // serial engine: data set on the same edge the shift rises, taken on that rise
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_r   <= lcdx_pkg::ST_IDLE;
      bit_cnt_r <= '0;
      shift_r   <= 1'b0;
      latch_r   <= 1'b0;
      phase_r   <= 1'b0;
      data_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (!run_ok || !exp_mode) begin
        // freeze: clocks and phase low, data line left as is
        shift_r   <= 1'b0;
        latch_r   <= 1'b0;
        phase_r   <= 1'b0;
        bit_cnt_r <= '0;
      end else if (tick && state_r == lcdx_pkg::ST_SHIFT) begin
        if (!shift_r) begin
          data_r  <= ram_bit;
          shift_r <= 1'b1;
        end else begin
          shift_r   <= 1'b0;
          bit_cnt_r <= last_bit ? '0 : bit_cnt_r + ADDR_W'(1);
        end
      end else if (tick && state_r == lcdx_pkg::ST_LATCH) begin
        latch_r <= !latch_r;
        // frame boundary flips the ac phase
        if (latch_r)
          phase_r <= !phase_r;
      end
    end
  end

  // pin and status registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      running_r <= 1'b0;
      oe_r      <= 1'b0;
      supply_r  <= 1'b0;
      port_r    <= 1'b0;
      level_r   <= 2'h0;
    end else begin
      running_r <= run_ok;
      oe_r      <= exp_mode && !is_standby;
      supply_r  <= drive_supply_switch_bit && !is_standby;
      port_r    <= exp_mode;
      level_r   <= {data_r, phase_r};
    end
  end

  // outputs
  assign ram_addr            = bit_cnt_r;
  assign exp_out             = '{latch_clk: latch_r, shift_clk: shift_r,
                                 ac_phase: phase_r, ser_data: data_r};
  assign exp_oe              = '{latch_clk: oe_r, shift_clk: oe_r,
                                 ac_phase: oe_r, ser_data: oe_r};
  assign seg_level_code      = level_r;
  assign drive_supply_on     = supply_r;
  assign lower_seg_port_mode = port_r;
  assign display_running     = running_r;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_run_drop;
    !run_ok ##1 1'b1;
  endsequence

  sequence s_frozen;
    !shift_r && !latch_r && !phase_r;
  endsequence

  // a load tick in the shift state while the link is allowed to run
  sequence s_bit_tick;
    tick && run_ok && exp_mode && (state_r == lcdx_pkg::ST_SHIFT) && !shift_r;
  endsequence

  // the closing latch tick of a frame: strobe high, about to fall
  sequence s_latch_end;
    tick && run_ok && exp_mode && (state_r == lcdx_pkg::ST_LATCH) && latch_r;
  endsequence

  a_standby_float: assert property (is_standby |=> exp_oe == '0)
    else $error("expansion pins driven in standby");
  a_supply_off: assert property (is_standby |=> !drive_supply_on)
    else $error("drive supply on in standby");
  a_freeze_pins: assert property (s_run_drop |-> s_frozen and $stable(data_r))
    else $error("expansion not frozen after run stop");
  a_run_clear: assert property (!display_run_bit |=> !display_running)
    else $error("display running with run bit clear");
  a_run_active: assert property
    (display_run_bit && sys_runs && !module_standby |=> display_running)
    else $error("display stopped in active or sleep");
  a_sub_source: assert property (sub_mode && !use_sub |=> !display_running)
    else $error("display runs without subclock source");
  a_mstby_halt: assert property (module_standby |=> !display_running)
    else $error("display runs in module standby");
  a_sub_blocked: assert property (is_standby |=> !display_running)
    else $error("display runs in standby");
  a_level_pair: assert property (##1 seg_level_code == $past({data_r, phase_r}))
    else $error("level code not from data and phase");
  // a strobe edge off a tick would cut a pulse short; freeze is the one
  // permitted exception, since stopping at once is mandated
  a_shift_width: assert property
    ($changed(shift_r) |-> $past(tick) || !$past(run_ok) || !$past(exp_mode))
    else $error("runt pulse on shift clock");
  a_port_mode: assert property (##1 lower_seg_port_mode == $past(exp_mode))
    else $error("lower segment port mode wrong");

  // latch strobe obeys the same pacing as the shift strobe
  a_latch_step: assert property
    ($changed(latch_r) |-> $past(tick) || !$past(run_ok) || !$past(exp_mode))
    else $error("runt pulse on latch clock");

  // the data line is loaded from ram in the same edge the shift rises
  a_bit_load: assert property
    (s_bit_tick |=> shift_r && (data_r == $past(ram_bit)))
    else $error("serial bit not taken from ram");

  // ac phase flips as the latch strobe falls at a frame end
  a_phase_flip: assert property
    (s_latch_end |=> !latch_r && (phase_r != $past(phase_r)))
    else $error("ac phase did not flip at frame end");

  // outside a frame end the phase holds, unless a freeze clears it
  a_phase_hold: assert property
    ($changed(phase_r) |-> $past(tick) || !$past(run_ok) || !$past(exp_mode))
    else $error("ac phase moved off a tick");

  // ram address never walks past the last column of the frame
  a_addr_range: assert property
    (ram_addr <= ADDR_W'(SER_BITS - 1))
    else $error("ram address beyond frame");

  // subclock modes keep the display alive on a subclock source
  a_sub_runs: assert property
    (display_run_bit && sub_mode && use_sub && !module_standby
     |=> display_running)
    else $error("display stopped on subclock source");

  // with expansion off the strobes stay low, so the far chip is quiet
  a_exp_quiet: assert property
    (!exp_mode |=> !exp_out.shift_clk && !exp_out.latch_clk)
    else $error("expansion strobes active while off");

endmodule
`default_nettype wire

// ### tb/lcdx_seg_driver.sv
// behavioural model of the external segment driver on the expansion link
`timescale 1ns/100ps
`default_nettype none
module lcdx_seg_driver #(
  parameter int unsigned NBITS = 80  // columns per driver chip
) (
  input  wire logic             latch_clk,    // latch strobe from the controller
  input  wire logic             shift_clk,    // shift strobe from the controller
  input  wire logic             ac_phase,     // ac phase line
  input  wire logic             ser_data,     // serial column data
  output var  logic [NBITS-1:0] frame,        // latched column image
  output var  logic             frame_phase,  // phase seen at the latch
  output var  int               frame_cnt     // latches seen so far
);
  logic [NBITS-1:0] shift_r;  // shift chain, first bit ends at the top
  // power-up contents of the chip
  initial begin
    shift_r = '0;
    frame = '0;
    frame_phase = 1'b0;
    frame_cnt = 0;
  end
  // only the newest bits are kept, so a frame cut by a freeze is pushed out
  always @(posedge shift_clk) begin
    shift_r <= {shift_r[NBITS-2:0], ser_data};
  end
  // phase is taken at the latch, since it flips only after the latch pulse
  always @(posedge latch_clk) begin
    frame <= shift_r;
    frame_phase <= ac_phase;
    frame_cnt <= frame_cnt + 1;
  end
endmodule
`default_nettype wire

// ### tb/tb_lcd_power_mode_and_expansion.sv
// self-checking bench for the lcd power-mode and segment-expansion block
`timescale 1ns/100ps
`default_nettype none
module tb_lcd_power_mode_and_expansion;
  logic                  sys_clk;      // 40 MHz system clock
  logic                  nrst;         // sync reset, active low
  lcdx_pkg::lcdx_pmode_e power_mode;   // power state from the bench
  logic                  module_standby;
  logic                  display_run_bit;
  logic [3:0]            frame_clock_select;
  logic                  drive_supply_switch_bit;
  logic                  expansion_select_bit;
  logic [3:0]            segment_pin_select_field;
  logic                  sub_clk_pin;  // free-running subclock oscillator
  logic                  ram_bit;
  logic [6:0]            ram_addr;
  lcdx_pkg::lcdx_exp_s   exp_out;
  lcdx_pkg::lcdx_exp_s   exp_oe;
  logic [1:0]            seg_level_code;
  logic                  drive_supply_on;
  logic                  lower_seg_port_mode;
  logic                  display_running;
  logic [127:0]          ram;          // display ram image
  logic [79:0]           frame;        // columns latched by the partner
  logic                  frame_phase;
  int                    frame_cnt;
  int                    err_total;
  int                    num_checks;
  // combinational ram read, as the controller expects
  assign ram_bit = ram[ram_addr];
  lcdx_ctrl #(.SER_BITS(80), .ADDR_W(7)) uut (
    .sys_clk(sys_clk), .nrst(nrst), .power_mode(power_mode),
    .module_standby(module_standby), .display_run_bit(display_run_bit),
    .frame_clock_select(frame_clock_select),
    .drive_supply_switch_bit(drive_supply_switch_bit),
    .expansion_select_bit(expansion_select_bit),
    .segment_pin_select_field(segment_pin_select_field), .sub_clk_pin(sub_clk_pin),
    .ram_bit(ram_bit), .ram_addr(ram_addr), .exp_out(exp_out), .exp_oe(exp_oe),
    .seg_level_code(seg_level_code), .drive_supply_on(drive_supply_on),
    .lower_seg_port_mode(lower_seg_port_mode), .display_running(display_running));
  lcdx_seg_driver #(.NBITS(80)) drv (
    .latch_clk(exp_out.latch_clk), .shift_clk(exp_out.shift_clk),
    .ac_phase(exp_out.ac_phase), .ser_data(exp_out.ser_data),
    .frame(frame), .frame_phase(frame_phase), .frame_cnt(frame_cnt));
  // system clock, 25 ns period
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // subclock at 200 ns, offset so each edge falls 0.5 ns before a system clock rise
  initial begin
    sub_clk_pin = 1'b0;
    #37;
    forever #100 sub_clk_pin = ~sub_clk_pin;
  end
  // shared comparison: counts every call, reports a difference at once
  task automatic check(input logic [79:0] seen, input logic [79:0] expd);
    num_checks++;
    if (seen !== expd) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expd);
    end
  endtask
  task automatic final_report;
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one power-state case; long settle covers the subclock synchroniser
  task automatic mode_case(input int m, input logic run, input logic sub);
    logic exp_run;
    @(negedge sys_clk);
    power_mode = lcdx_pkg::lcdx_pmode_e'(m[2:0]);
    display_run_bit = run;
    frame_clock_select = {sub, 1'b0, 2'($urandom)};
    module_standby = 1'($urandom);
    drive_supply_switch_bit = 1'($urandom);
    expansion_select_bit = 1'($urandom);
    segment_pin_select_field = 4'($urandom % 3);
    exp_run = run && !module_standby && (m == 1 || m == 2 || (m >= 3 && m <= 5 && sub));
    repeat (24) @(negedge sys_clk);
    check(80'(display_running), 80'(exp_run));
    check(80'(drive_supply_on), 80'(drive_supply_switch_bit && m != 6));
    check(80'(lower_seg_port_mode), 80'(expansion_select_bit && segment_pin_select_field < 2));
    check(80'(exp_oe), 80'({4{expansion_select_bit && segment_pin_select_field < 2 && m != 6}}));
  endtask
  // wait for the next latch from the partner, bounded
  task automatic wait_frame;
    int n0;
    n0 = frame_cnt;
    for (int i = 0; i < 4000 && frame_cnt == n0; i++) @(negedge sys_clk);
    check(80'(frame_cnt != n0), 80'h1);
  endtask
  // two frames in one clock setup, then a freeze in mid-frame
  task automatic frame_case(input int m, input logic [3:0] fcs);
    logic p1;
    logic d;
    @(negedge sys_clk);
    display_run_bit = 1'b0;
    frame_clock_select = fcs;
    power_mode = lcdx_pkg::lcdx_pmode_e'(m[2:0]);
    module_standby = 1'b0;
    expansion_select_bit = 1'b1;
    segment_pin_select_field = 4'($urandom % 2);
    repeat (3) @(negedge sys_clk);
    display_run_bit = 1'b1;
    wait_frame();
    check(frame, {<<{ram[79:0]}});
    p1 = frame_phase;
    wait_frame();
    check(frame, {<<{ram[79:0]}});
    check(80'(frame_phase), 80'(!p1));
    repeat (5 + $urandom % 200) @(negedge sys_clk);
    display_run_bit = 1'b0;
    repeat (3) @(negedge sys_clk);
    d = exp_out.ser_data;
    check(80'(seg_level_code), 80'({d, 1'b0}));
    check(80'(ram_addr), 80'h0);
    repeat (8) begin
      @(negedge sys_clk);
      check(80'(exp_out), {76'h0, 3'h0, d});
    end
  endtask
  // main sequence
  initial begin
    err_total = 0;
    num_checks = 0;
    $urandom(22);
    ram = {$urandom, $urandom, $urandom, $urandom};
    nrst = 1'b0;
    power_mode = lcdx_pkg::PM_RESET;
    module_standby = 1'b0;
    display_run_bit = 1'b0;
    frame_clock_select = 4'h0;
    drive_supply_switch_bit = 1'b1;
    expansion_select_bit = 1'b0;
    segment_pin_select_field = 4'h0;
    repeat (4) @(negedge sys_clk);
    check(80'({exp_out, exp_oe, drive_supply_on, display_running}), 80'h0);
    nrst = 1'b1;
    for (int m = 0; m < 7; m++)
      for (int k = 0; k < 4; k++) mode_case(m, k[0], k[1]);
    frame_case(1, 4'h0);
    frame_case(4, 4'h8);
    frame_case(2, 4'h9);
    final_report();
  end
  // watchdog: the whole run needs well under half a millisecond
  initial begin
    #1ms;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
